/* srxs_pkg.sv */
// What this block does
// - logical lane 7 takes physical input chosen by crossbar bits 5:3, reset 7.
// - logical lane 6 takes physical input chosen by crossbar bits 2:0, reset 6.
// - full-flag bit x reads high while logical lane x receive FIFO is full.
// - empty-flag bit x reads high while logical lane x receive FIFO is empty.
// - at multiframe end, any character error in that multiframe raises a sync error.
// - sync error low pulse length set by bits 5:4: one cycle for codes 0 and 1, two cycles for codes 2 and 3.
// - enable bit x turns on the bit-error test of lane x.
// - control bits 6:4 choose which lane's error count is reported.
// - control bits 3:2 choose PRBS7, PRBS15 or PRBS31.
// - control bit 1 runs the test while set, stops it while clear.
// - control bit 0 holds the test state machines and counters in reset.
// - each lane error count is compared with a 24-bit limit in three bytes.
// - selected lane 24-bit error count is read back over three byte registers.
// - pass bit x is one while lane x count is below limit; resets to 0xFF.
package srxs_pkg;

    localparam int LANES       = 8;
    localparam int ADR_W       = 12;
    localparam int IDX_W       = 10;
    localparam int CNT_W       = 24;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_XBAR     = 10'h30B;
    localparam logic [IDX_W-1:0] IDX_FULL     = 10'h30C;
    localparam logic [IDX_W-1:0] IDX_EMPTY    = 10'h30D;
    localparam logic [IDX_W-1:0] IDX_SYNCCTL  = 10'h312;
    localparam logic [IDX_W-1:0] IDX_PHYSETUP = 10'h314;
    localparam logic [IDX_W-1:0] IDX_BERTEN   = 10'h315;
    localparam logic [IDX_W-1:0] IDX_BERTCTL  = 10'h316;
    localparam logic [IDX_W-1:0] IDX_LIM_LO   = 10'h317;
    localparam logic [IDX_W-1:0] IDX_LIM_MID  = 10'h318;
    localparam logic [IDX_W-1:0] IDX_LIM_HI   = 10'h319;
    localparam logic [IDX_W-1:0] IDX_CNT_LO   = 10'h31A;
    localparam logic [IDX_W-1:0] IDX_CNT_MID  = 10'h31B;
    localparam logic [IDX_W-1:0] IDX_CNT_HI   = 10'h31C;
    localparam logic [IDX_W-1:0] IDX_PASS     = 10'h31D;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h320;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h321;

    // reset values
    localparam logic [7:0] RST_XBAR    = 8'h3E;
    localparam logic [7:0] RST_SYNCCTL = 8'h00;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_PASS    = 8'hFF;

    // field positions
    localparam int XBAR_SEVEN_LSB = 3;
    localparam int XBAR_SIX_LSB   = 0;
    localparam int PULSE_LEN_LSB  = 4;
    localparam int CTL_LANE_LSB   = 4;
    localparam int CTL_SEQ_LSB    = 2;
    localparam int CTL_RUN_BIT    = 1;
    localparam int CTL_HOLD_BIT   = 0;
    localparam logic [7:0] CTL_RW_MASK = 8'h7F;

    // interrupt status bits
    localparam int IRQ_SYNC_ERR  = 0;
    localparam int IRQ_PASS_LOST = 1;
    localparam int IRQ_FULL      = 2;
    localparam int IRQ_EMPTY     = 3;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h0F;

    // sync error pulse length codes
    localparam logic [1:0] PULSE_HALF = 2'h0;
    localparam logic [1:0] PULSE_ONE  = 2'h1;
    localparam logic [1:0] PULSE_TWO  = 2'h2;
    localparam logic [1:0] CYC_SHORT  = 2'h1;
    localparam logic [1:0] CYC_LONG   = 2'h2;

    // sequence select codes
    localparam logic [1:0] SEQ_PRBS7  = 2'h0;
    localparam logic [1:0] SEQ_PRBS15 = 2'h1;
    localparam logic [1:0] SEQ_PRBS31 = 2'h2;

    // consecutive matching bits needed before a checker counts errors
    localparam logic [5:0] LOCK_MATCHES = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } srxs_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } srxs_wb_rsp_type;

endpackage

/* srxs_lane_checker.sv */
`timescale 1ns/1ps
module srxs_lane_checker
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     hold_i,
    input  wire logic                     enable_i,
    input  wire logic                     run_i,
    input  wire logic [1:0]               seq_sel_i,
    input  wire logic                     bit_i,
    input  wire logic [srxs_pkg::CNT_W-1:0] limit_i,
    output logic      [srxs_pkg::CNT_W-1:0] err_count_o,
    output logic                          pass_o
);
    import srxs_pkg::*;

    typedef enum logic {ST_HUNT, ST_LOCKED} srxs_chk_state_type;

    srxs_chk_state_type state_reg, state_next;
    logic [30:0]      hist_reg, hist_next;
    logic [5:0]       match_reg, match_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic             pass_reg, pass_next;
    logic             predicted;
    logic             active;

    // self-synchronising prediction from the received history
    always_comb
    begin
        case (seq_sel_i)
            SEQ_PRBS7:  predicted = hist_reg[6] ^ hist_reg[5];
            SEQ_PRBS15: predicted = hist_reg[14] ^ hist_reg[13];
            SEQ_PRBS31: predicted = hist_reg[30] ^ hist_reg[27];
            default:    predicted = hist_reg[30] ^ hist_reg[27];
        endcase
    end

    assign active = enable_i & run_i;

    // lock search, then mismatch counting
    always_comb
    begin
        state_next = state_reg;
        hist_next  = hist_reg;
        match_next = match_reg;
        count_next = count_reg;
        pass_next  = count_reg < limit_i;
        if (active)
        begin
            hist_next = {hist_reg[29:0], bit_i};
            case (state_reg)
                ST_HUNT:
                begin
                    if (bit_i != predicted)
                        match_next = 6'h00;
                    else if (match_reg == LOCK_MATCHES - 6'h01)
                        state_next = ST_LOCKED;
                    else
                        match_next = match_reg + 6'h01;
                end
                ST_LOCKED:
                begin
                    if ((bit_i != predicted) && (count_reg != CNT_MAX))
                        count_next = count_reg + 24'h000001;
                end
                default:
                    state_next = ST_HUNT;
            endcase
        end
        else if (state_reg == ST_HUNT)
            match_next = 6'h00;
    end

    // hold bit acts as a reset of the checker and its counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || hold_i)
        begin
            state_reg <= ST_HUNT;
            hist_reg  <= 31'h00000000;
            match_reg <= 6'h00;
            count_reg <= 24'h000000;
            pass_reg  <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            hist_reg  <= hist_next;
            match_reg <= match_next;
            count_reg <= count_next;
            pass_reg  <= pass_next;
        end
    end

    assign err_count_o = count_reg;
    assign pass_o      = pass_reg;
endmodule

/* srxs_top.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module srxs_top
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire srxs_pkg::srxs_wb_req_type wb_req_i,
    output srxs_pkg::srxs_wb_rsp_type      wb_rsp_o,
    input  wire logic [7:0]                serial_input_i,
    input  wire logic [7:0]                fifo_full_i,
    input  wire logic [7:0]                fifo_empty_i,
    input  wire logic [7:0]                char_error_i,
    input  wire logic                      multiframe_end_i,
    output logic                           logical_six_o,
    output logic                           logical_seven_o,
    output logic                           sync_output_zero_n_o,
    output logic                           sync_output_one_n_o,
    output logic [7:0]                     serial_phy_setup_value_o,
    output logic                           irq_o
);
    import srxs_pkg::*;

    // picks one physical lane bit by index
    function automatic logic lane_pick(input logic [7:0] lanes, input logic [2:0] idx);
        lane_pick = lanes[idx];
    endfunction

    // register state
    logic [7:0]       xbar_reg, xbar_next;
    logic [7:0]       syncctl_reg, syncctl_next;
    logic [7:0]       phy_reg, phy_next;
    logic [7:0]       berten_reg, berten_next;
    logic [7:0]       bertctl_reg, bertctl_next;
    logic [CNT_W-1:0] limit_reg, limit_next;
    logic [7:0]       irq_stat_reg, irq_stat_next;
    logic [7:0]       irq_mask_reg, irq_mask_next;
    logic             ack_reg, ack_next;
    logic [31:0]      rdat_reg, rdat_next;
    logic             irq_reg, irq_next;

    // lane and sync state
    logic [7:0]       meta_reg, lane_sync_reg;
    logic             six_reg, six_next;
    logic             seven_reg, seven_next;
    logic [7:0]       full_reg, empty_reg;
    logic             err_seen_reg, err_seen_next;
    logic [1:0]       low_cnt_reg, low_cnt_next;
    logic             sync_n_reg, sync_n_next;
    logic             sync_event;

    logic [CNT_W-1:0] lane_count [LANES];
    logic [7:0]       lane_pass;
    logic [7:0]       pass_prev_reg;
    logic [CNT_W-1:0] sel_count;
    logic [IDX_W-1:0] idx;
    logic             wr_commit;
    logic [7:0]       wbyte;
    logic [7:0]       irq_events;

    assign idx       = wb_req_i.adr[ADR_W-1:2];
    assign wr_commit = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_reg & wb_req_i.sel[0];
    assign wbyte     = wb_req_i.dat[7:0];
    assign sel_count = lane_count[bertctl_reg[CTL_LANE_LSB +: 3]];

    // two-flop synchroniser for the physical lane pins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg      <= 8'h00;
            lane_sync_reg <= 8'h00;
        end
        else
        begin
            meta_reg      <= serial_input_i;
            lane_sync_reg <= meta_reg;
        end
    end

    // one bit-error checker per physical lane
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : gen_lane
            srxs_lane_checker u_chk
            (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .hold_i      (bertctl_reg[CTL_HOLD_BIT]),
                .enable_i    (berten_reg[g]),
                .run_i       (bertctl_reg[CTL_RUN_BIT]),
                .seq_sel_i   (bertctl_reg[CTL_SEQ_LSB +: 2]),
                .bit_i       (lane_sync_reg[g]),
                .limit_i     (limit_reg),
                .err_count_o (lane_count[g]),
                .pass_o      (lane_pass[g])
            );
        end
    endgenerate

    // crossbar for the upper logical lanes
    always_comb
    begin
        seven_next = lane_pick(lane_sync_reg, xbar_reg[XBAR_SEVEN_LSB +: 3]);
        six_next   = lane_pick(lane_sync_reg, xbar_reg[XBAR_SIX_LSB +: 3]);
    end

    // error collection over a multiframe and the low pulse on sync
    always_comb
    begin
        sync_event    = multiframe_end_i & (err_seen_reg | (|char_error_i));
        err_seen_next = err_seen_reg | (|char_error_i);
        if (multiframe_end_i)
            err_seen_next = 1'b0;
        low_cnt_next = low_cnt_reg;
        if (sync_event)
        begin
            case (syncctl_reg[PULSE_LEN_LSB +: 2])
                PULSE_HALF: low_cnt_next = CYC_SHORT;
                PULSE_ONE:  low_cnt_next = CYC_SHORT;
                PULSE_TWO:  low_cnt_next = CYC_LONG;
                default:    low_cnt_next = CYC_LONG;
            endcase
        end
        else if (low_cnt_reg != 2'h0)
            low_cnt_next = low_cnt_reg - 2'h1;
        sync_n_next = ~(sync_event | (low_cnt_reg > 2'h1));
    end

    // lane and sync registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            six_reg       <= 1'b0;
            seven_reg     <= 1'b0;
            full_reg      <= 8'h00;
            empty_reg     <= 8'h00;
            err_seen_reg  <= 1'b0;
            low_cnt_reg   <= 2'h0;
            sync_n_reg    <= 1'b1;
            pass_prev_reg <= RST_PASS;
        end
        else
        begin
            six_reg       <= six_next;
            seven_reg     <= seven_next;
            full_reg      <= fifo_full_i;
            empty_reg     <= fifo_empty_i;
            err_seen_reg  <= err_seen_next;
            low_cnt_reg   <= low_cnt_next;
            sync_n_reg    <= sync_n_next;
            pass_prev_reg <= lane_pass;
        end
    end

    // interrupt events: sync error, lost pass, FIFO flags rising
    always_comb
    begin
        irq_events                = 8'h00;
        irq_events[IRQ_SYNC_ERR]  = sync_event;
        irq_events[IRQ_PASS_LOST] = |(pass_prev_reg & ~lane_pass);
        irq_events[IRQ_FULL]      = |(fifo_full_i & ~full_reg);
        irq_events[IRQ_EMPTY]     = |(fifo_empty_i & ~empty_reg);
    end

    // bus slave and software registers
    always_comb
    begin
        xbar_next     = xbar_reg;
        syncctl_next  = syncctl_reg;
        phy_next      = phy_reg;
        berten_next   = berten_reg;
        bertctl_next  = bertctl_reg;
        limit_next    = limit_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        ack_next      = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
        rdat_next     = 32'h00000000;
        if (wr_commit)
        begin
            case (idx)
                IDX_XBAR:     xbar_next = {2'b00, wbyte[5:0]};
                IDX_SYNCCTL:  syncctl_next = wbyte;
                IDX_PHYSETUP: phy_next = wbyte;
                IDX_BERTEN:   berten_next = wbyte;
                IDX_BERTCTL:  bertctl_next = wbyte & CTL_RW_MASK;
                IDX_LIM_LO:   limit_next[7:0] = wbyte;
                IDX_LIM_MID:  limit_next[15:8] = wbyte;
                IDX_LIM_HI:   limit_next[23:16] = wbyte;
                IDX_IRQ_MASK: irq_mask_next = wbyte & IRQ_BITS_MASK;
                IDX_IRQ_STAT: irq_stat_next = irq_stat_reg & ~wbyte;
                default:      xbar_next = xbar_reg;
            endcase
        end
        // a new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | irq_events;
        if (wb_req_i.cyc && wb_req_i.stb && !ack_reg)
        begin
            case (idx)
                IDX_XBAR:     rdat_next[7:0] = xbar_reg;
                IDX_FULL:     rdat_next[7:0] = full_reg;
                IDX_EMPTY:    rdat_next[7:0] = empty_reg;
                IDX_SYNCCTL:  rdat_next[7:0] = syncctl_reg;
                IDX_PHYSETUP: rdat_next[7:0] = phy_reg;
                IDX_BERTEN:   rdat_next[7:0] = berten_reg;
                IDX_BERTCTL:  rdat_next[7:0] = bertctl_reg;
                IDX_LIM_LO:   rdat_next[7:0] = limit_reg[7:0];
                IDX_LIM_MID:  rdat_next[7:0] = limit_reg[15:8];
                IDX_LIM_HI:   rdat_next[7:0] = limit_reg[23:16];
                IDX_CNT_LO:   rdat_next[7:0] = sel_count[7:0];
                IDX_CNT_MID:  rdat_next[7:0] = sel_count[15:8];
                IDX_CNT_HI:   rdat_next[7:0] = sel_count[23:16];
                IDX_PASS:     rdat_next[7:0] = lane_pass;
                IDX_IRQ_STAT: rdat_next[7:0] = irq_stat_reg;
                IDX_IRQ_MASK: rdat_next[7:0] = irq_mask_reg;
                default:      rdat_next = 32'h00000000;
            endcase
        end
        irq_next = |(irq_stat_reg & irq_mask_reg);
    end

    // register file storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xbar_reg     <= RST_XBAR;
            syncctl_reg  <= RST_SYNCCTL;
            phy_reg      <= RST_ZERO;
            berten_reg   <= RST_ZERO;
            bertctl_reg  <= RST_ZERO;
            limit_reg    <= 24'h000000;
            irq_stat_reg <= RST_ZERO;
            irq_mask_reg <= RST_ZERO;
            ack_reg      <= 1'b0;
            rdat_reg     <= 32'h00000000;
            irq_reg      <= 1'b0;
        end
        else
        begin
            xbar_reg     <= xbar_next;
            syncctl_reg  <= syncctl_next;
            phy_reg      <= phy_next;
            berten_reg   <= berten_next;
            bertctl_reg  <= bertctl_next;
            limit_reg    <= limit_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            ack_reg      <= ack_next;
            rdat_reg     <= rdat_next;
            irq_reg      <= irq_next;
        end
    end

    // outputs straight from flip-flops
    assign wb_rsp_o.ack             = ack_reg;
    assign wb_rsp_o.dat             = rdat_reg;
    assign logical_six_o            = six_reg;
    assign logical_seven_o          = seven_reg;
    assign sync_output_zero_n_o     = sync_n_reg;
    assign sync_output_one_n_o      = sync_n_reg;
    assign serial_phy_setup_value_o = phy_reg;
    assign irq_o                    = irq_reg;
endmodule

/* srxs_assertions.sv */
`timescale 1ns/1ps
// port-level checks of the lane status and test block
module srxs_assertions
(
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire srxs_pkg::srxs_wb_req_type wb_req_i,
    input wire srxs_pkg::srxs_wb_rsp_type wb_rsp_o,
    input wire logic [7:0]                serial_input_i,
    input wire logic [7:0]                fifo_full_i,
    input wire logic                      multiframe_end_i,
    input wire logic                      logical_six_o,
    input wire logic                      logical_seven_o,
    input wire logic                      sync_output_zero_n_o,
    input wire logic                      sync_output_one_n_o
);
    import srxs_pkg::*;
    logic        req;
    logic [5:0]  xbar_reg;
    logic [5:0]  xbar_next;
    logic [17:0] pipe_reg;
    logic [17:0] pipe_next;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // crossbar shadow follows bus writes; pins pass two flops, then the mux
    assign req = wb_req_i.cyc && wb_req_i.stb;
    always_comb
    begin
        xbar_next = xbar_reg;
        if (req && wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
            && wb_req_i.adr[11:2] == IDX_XBAR)
            xbar_next = wb_req_i.dat[5:0];
        pipe_next = {serial_input_i, pipe_reg[17:10], pipe_reg[2 + xbar_reg[5:3]],
                     pipe_reg[2 + xbar_reg[2:0]]};
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xbar_reg <= RST_XBAR[5:0];
            pipe_reg <= 18'h00000;
        end
        else
        begin
            xbar_reg <= xbar_next;
            pipe_reg <= pipe_next;
        end
    end

    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held for more than one cycle");
    ack_answer_a: assert property (req && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("request not answered in the next cycle");
    ack_idle_a: assert property (!req |=> !wb_rsp_o.ack)
        else $error("ack without a request");
    rsp_upper_a: assert property (wb_rsp_o.dat[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    sync_pair_a: assert property (sync_output_zero_n_o == sync_output_one_n_o)
        else $error("sync outputs differ");
    sync_cause_a: assert property ($fell(sync_output_zero_n_o) |-> $past(multiframe_end_i))
        else $error("sync low without multiframe end");
    pulse_len_a: assert property (!sync_output_zero_n_o ##1 !sync_output_zero_n_o
        |=> sync_output_zero_n_o || $past(multiframe_end_i))
        else $error("sync low pulse too long");
    lane_seven_a: assert property (logical_seven_o == pipe_reg[1])
        else $error("logical lane seven source wrong");
    lane_six_a: assert property (logical_six_o == pipe_reg[0])
        else $error("logical lane six source wrong");
    full_read_a: assert property (wb_rsp_o.ack && $past(fifo_full_i) == $past(fifo_full_i, 2)
        && $past(req && !wb_req_i.we && wb_req_i.adr[11:2] == IDX_FULL)
        |-> wb_rsp_o.dat[7:0] == $past(fifo_full_i, 2))
        else $error("full flag read differs from inputs");

    // main scenarios
    cover property (req && wb_req_i.we ##1 wb_rsp_o.ack);
    cover property ($fell(sync_output_zero_n_o) ##1 !sync_output_zero_n_o);
    cover property ($rose(logical_seven_o));
endmodule

/* srxs_prbs_source.sv */
`timescale 1ns/1ps
// transmitter model: self-synchronising sequence on every lane
module srxs_prbs_source
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] seq_sel_i,
    input  wire logic       flip_i,
    output logic            bit_o
);
    logic [30:0] shift_reg;
    logic [30:0] shift_next;
    logic        fb;

    // feedback from the taps of the chosen polynomial
    always_comb
    begin
        case (seq_sel_i)
            2'h0:    fb = shift_reg[6] ^ shift_reg[5];
            2'h1:    fb = shift_reg[14] ^ shift_reg[13];
            default: fb = shift_reg[30] ^ shift_reg[27];
        endcase
        shift_next = {shift_reg[29:0], fb};
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shift_reg <= 31'h00000001;
        else
            shift_reg <= shift_next;
    end
    // a flipped line bit leaves the generator intact
    assign bit_o = shift_reg[0] ^ flip_i;
endmodule

/* srxs_top_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the lane status and test block
module srxs_top_tb;
    import srxs_pkg::*;
    typedef struct packed {logic we; logic [9:0] ix; logic [7:0] wr; logic [7:0] rd;} srxs_row_type;
    logic            clk_i    = 1'b0;
    logic            rst_i    = 1'b1;
    srxs_wb_req_type wb_req   = '0;
    srxs_wb_rsp_type wb_rsp;
    logic [7:0]      pins     = 8'h00;
    logic [7:0]      full_in  = 8'h00;
    logic [7:0]      empty_in = 8'h00;
    logic [7:0]      char_err = 8'h00;
    logic [1:0]      seq      = 2'h0;
    logic            pin_mode = 1'b0;
    logic            mf_end   = 1'b0;
    logic            flip     = 1'b0;
    logic            six, seven, sync0, sync1, irq, prbs_bit;
    logic [7:0]      phy, q;
    int              n_errors = 0;
    int              checked  = 0;
    int              lows;
    srxs_row_type    rows [10] = '{'{0, IDX_XBAR, 8'h00, 8'h3E}, '{0, IDX_BERTCTL, 8'h00, 8'h00},
        '{1, IDX_PHYSETUP, 8'h01, 8'h01}, '{1, IDX_XBAR, 8'hFF, 8'h3F},
        '{1, IDX_BERTCTL, 8'hFF, 8'h7F}, '{1, IDX_SYNCCTL, 8'hA5, 8'hA5},
        '{1, IDX_FULL, 8'hFF, 8'h00}, '{1, IDX_CNT_LO, 8'hFF, 8'h00},
        '{1, 10'h3FF, 8'hFF, 8'h00}, '{1, IDX_LIM_HI, 8'h5A, 8'h5A}};

    srxs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .serial_input_i(pin_mode ? pins : {8{prbs_bit}}), .fifo_full_i(full_in),
        .fifo_empty_i(empty_in), .char_error_i(char_err), .multiframe_end_i(mf_end),
        .logical_six_o(six), .logical_seven_o(seven), .sync_output_zero_n_o(sync0),
        .sync_output_one_n_o(sync1), .serial_phy_setup_value_o(phy), .irq_o(irq));
    srxs_prbs_source u_src (.clk_i(clk_i), .rst_i(rst_i), .seq_sel_i(seq), .flip_i(flip),
        .bit_o(prbs_bit));

    // clock and reset
    always #4 clk_i = ~clk_i;
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    end

    // count, compare and finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one classic bus cycle, held until ack is seen
    task automatic wb(input logic we, input logic [9:0] ix, input logic [7:0] d);
        @(posedge clk_i);
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we  <= we;
        wb_req.sel <= 4'h1;
        wb_req.adr <= {ix, 2'b00};
        wb_req.dat <= {24'h000000, d};
        do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat[7:0];
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] ix, input logic [7:0] exp);
        wb(1'b0, ix, 8'h00);
        chk(q, exp);
    endtask
    task automatic inject();
        @(posedge clk_i) flip <= 1'b1;
        @(posedge clk_i) flip <= 1'b0;
        repeat (40) @(posedge clk_i);
    endtask

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("[ERR] t=%0t timeout got %h exp %h", $time, 1'b0, 1'b1);
        end_sim();
    end

    initial
    begin
        wait (rst_i === 1'b0);
        foreach (rows[i])
        begin
            if (rows[i].we)
                wb(1'b1, rows[i].ix, rows[i].wr);
            rd(rows[i].ix, rows[i].rd);
        end
        chk(phy, 8'h01);
        $display("register rows done");
        // crossbar: each source index for lane seven, its mirror for lane six
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, IDX_XBAR, {2'b00, i[2:0], 3'(7 - i)});
            for (int b = 0; b < 2; b++)
            begin
                @(posedge clk_i);
                pin_mode <= 1'b1;
                pins <= b[0] ? ~(8'h01 << i) : (8'h01 << i);
                repeat (4) @(posedge clk_i);
                @(negedge clk_i);
                chk({7'h00, seven}, {7'h00, !b[0]});
                chk({7'h00, six}, {7'h00, b[0]});
            end
        end
        pin_mode <= 1'b0;
        $display("crossbar done");
        // fifo flags and interrupt raise, mask and clear
        wb(1'b1, IDX_IRQ_STAT, 8'h0F);
        wb(1'b1, IDX_IRQ_MASK, 8'h04);
        rd(IDX_IRQ_STAT, 8'h00);
        @(posedge clk_i) full_in <= 8'hA5;
        empty_in <= 8'h5A;
        repeat (3) @(posedge clk_i);
        rd(IDX_FULL, 8'hA5);
        rd(IDX_EMPTY, 8'h5A);
        rd(IDX_IRQ_STAT, 8'h0C);
        chk({7'h00, irq}, 8'h01);
        wb(1'b1, IDX_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq}, 8'h00);
        wb(1'b1, IDX_IRQ_STAT, 8'h0C);
        rd(IDX_IRQ_STAT, 8'h00);
        $display("flags and interrupt done");
        // sync error pulse for each length code, then a clean multiframe
        for (int c = 0; c < 5; c++)
        begin
            wb(1'b1, IDX_SYNCCTL, {2'b00, c[1:0], 4'h0});
            @(posedge clk_i) char_err <= (c == 4) ? 8'h00 : 8'h10;
            @(posedge clk_i) char_err <= 8'h00;
            mf_end <= 1'b1;
            @(posedge clk_i) mf_end <= 1'b0;
            lows = 0;
            repeat (6) @(negedge clk_i) lows += int'(sync0 === 1'b0);
            chk(lows[7:0], (c == 4) ? 8'h00 : (c >= 2) ? 8'h02 : 8'h01);
        end
        $display("sync pulse done");
        // bit-error test for each sequence; lane 3 disabled
        wb(1'b1, IDX_BERTEN, 8'hF7);
        wb(1'b1, IDX_LIM_LO, 8'h04);
        wb(1'b1, IDX_LIM_HI, 8'h00);
        for (int s = 0; s < 3; s++)
        begin
            seq <= s[1:0];
            wb(1'b1, IDX_BERTCTL, {4'h4, s[1:0], 2'b01});
            wb(1'b1, IDX_BERTCTL, {4'h4, s[1:0], 2'b10});
            repeat (120) @(posedge clk_i);
            inject();
            rd(IDX_CNT_LO, 8'h03);
            rd(IDX_PASS, 8'hFF);
            inject();
            rd(IDX_CNT_LO, 8'h06);
            rd(IDX_CNT_MID, 8'h00);
            rd(IDX_PASS, 8'h08);
            wb(1'b1, IDX_BERTCTL, {4'h3, s[1:0], 2'b00});
            inject();
            rd(IDX_CNT_LO, 8'h00);
            wb(1'b1, IDX_BERTCTL, {4'h4, s[1:0], 2'b00});
            rd(IDX_CNT_LO, 8'h06);
            wb(1'b1, IDX_BERTCTL, {4'h4, s[1:0], 2'b01});
            rd(IDX_CNT_LO, 8'h00);
            rd(IDX_PASS, 8'hFF);
        end
        $display("bit-error test done");
        // second reset in mid-run restores defaults
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h00, sync0}, 8'h01);
        rst_i <= 1'b0;
        rd(IDX_XBAR, 8'h3E);
        rd(IDX_BERTEN, 8'h00);
        rd(IDX_PHYSETUP, 8'h00);
        $display("second reset done");
        end_sim();
    end
endmodule

bind srxs_top srxs_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .serial_input_i(serial_input_i), .fifo_full_i(fifo_full_i),
    .multiframe_end_i(multiframe_end_i), .logical_six_o(logical_six_o),
    .logical_seven_o(logical_seven_o), .sync_output_zero_n_o(sync_output_zero_n_o),
    .sync_output_one_n_o(sync_output_one_n_o));
